// *** ir_pkg.sv ***
// package: register map, field layout and types for the infrared transceiver
package ir_pkg;
  localparam int FIFO_DEPTH = 8;
  localparam int CNT_W      = 4;

  // register offsets (byte addresses)
  localparam logic [7:0] REG_TX_FIFO   = 8'h00;
  localparam logic [7:0] REG_RX_FIFO   = 8'h04;
  localparam logic [7:0] REG_CTRL      = 8'h08;
  localparam logic [7:0] REG_CARRIER   = 8'h0C;
  localparam logic [7:0] REG_SAMPLE    = 8'h10;
  localparam logic [7:0] REG_COMP      = 8'h14;
  localparam logic [7:0] REG_THRESH    = 8'h18;
  localparam logic [7:0] REG_CNT_LIMIT = 8'h1C;
  localparam logic [7:0] REG_IRQ_EN    = 8'h20;
  localparam logic [7:0] REG_IRQ_MASK  = 8'h24;
  localparam logic [7:0] REG_IRQ_RAW   = 8'h28;
  localparam logic [7:0] REG_IRQ_CLR   = 8'h2C;
  localparam logic [7:0] REG_STATUS    = 8'h30;
  localparam logic [7:0] REG_COMMAND   = 8'h34;

  // control register bits
  localparam int CTRL_TX_EN   = 0;
  localparam int CTRL_RX_EN   = 1;
  localparam int CTRL_MODE_RX = 2;
  localparam int CTRL_MANUAL  = 3;
  localparam int CTRL_CNT_HI  = 4;
  // command register bits (self clearing)
  localparam int CMD_TX_FLUSH = 0;
  localparam int CMD_RX_FLUSH = 1;
  localparam int CMD_RX_START = 2;

  // symbol word fields
  localparam int TX_TYPE_BIT  = 31;
  localparam int TX_LAST_BIT  = 30;
  localparam int TX_COMP_HI   = 29;
  localparam int TX_COMP_LO   = 28;
  localparam int TX_CNT_W     = 28;
  localparam int RX_LEVEL_BIT = 31;
  localparam int RX_CNT_W     = 31;
  localparam int LIMIT_W      = 27;
  localparam logic [1:0] COMP_AUX = 2'h3;

  // interrupt source positions
  localparam int IRQ_N          = 9;
  localparam int IRQ_TX_EMPTY   = 0;
  localparam int IRQ_TX_LEVEL   = 1;
  localparam int IRQ_TX_OVER    = 2;
  localparam int IRQ_RX_FULL    = 3;
  localparam int IRQ_RX_LEVEL   = 4;
  localparam int IRQ_RX_CNT_OF  = 5;
  localparam int IRQ_RX_OVER    = 6;
  localparam int IRQ_RX_CNT_THR = 7;
  localparam int IRQ_RX_ERR     = 8;

  localparam logic [15:0] DIV_RESET  = 16'h0010;
  localparam logic [15:0] HIGH_RESET = 16'h0008;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_LOAD = 2'b01,
    TX_RUN  = 2'b10
  } tx_state_t;
endpackage : ir_pkg

// *** ir_transceiver.sv ***
// infrared transceiver: carrier modulator, level capture, register port
//
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
// Functional notes
// [R1] tx word bit 31 selects carrier on
// [R2] tx bit 30 ends the transmission
// [R3] tx low 28 bits count carrier periods
// [R4] carrier made in hardware, steady when off
// [R5] rx timing each level pushes one word
// [R6] rx bit 31: zero high, one low
// [R7] rx low 31 bits count sample ticks
// [R8] tx level irq when count <= threshold
// [R9] rx level irq when count > threshold
// [R10] selected level duration reaching limit raises irq
// [R11] duration limit uses full 27-bit field
// [R12] reading empty rx fifo raises error
// [R13] nine interrupt sources, each enabled
// [R14] separate mask; raw and mask readable
// [R15] per-bit write-one clear of pending bits
// [R16] engine running/idle status readable
// [R17] tx/rx mode select with enables
// [R18] tx free entries readable
// [R19] rx entry count readable
// [R20] manual rx waits for start command
// [R21] compensation method 3 times idle on aux clock
// [R22] programmable carrier and sample dividers
// [R23] independent tx and rx flush
module ir_transceiver
  import ir_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        srst_i,
  // register port
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  // infrared pins
  input  wire logic        infrared_input_pin_i,
  output logic             infrared_output_pin_o,
  // interrupt line
  output logic             irq_o
);
  // bus request bundled for the decode helper;
  // strobes are one cycle, so no request is ever held
  // over from one access to the next
  bus_req_t req;
  assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  // write and read strobes never rise together; the helper
  // still looks only at the strobe that the caller asks for
  // shared helper: is the bus strobing this register
  function automatic logic hit(input bus_req_t r, input logic [7:0] a, input logic w);
    hit = (w ? r.wr : r.rd) && (r.addr == a);
  endfunction : hit

  // software-visible configuration and interrupt state;
  // dividers reset to a slow carrier so a stray enable
  // before setup cannot drive a fast waveform
  logic [4:0]         ctrl_q;
  logic [15:0]        car_div_q, car_high_q, smp_div_q, comp_div_q;
  logic [CNT_W-1:0]   tx_thr_q, rx_thr_q;
  logic [LIMIT_W-1:0] limit_q;
  logic [IRQ_N-1:0]   irq_en_q, irq_mask_q, irq_raw_q, irq_set;
  logic               start_q;

  // flush command bits act only in the cycle of the write;
  // nothing is stored, so a flush cannot repeat itself
  // tx runs only in tx mode and rx only in rx mode
  wire tx_flush = hit(req, REG_COMMAND, 1'b1) && wdata_i[CMD_TX_FLUSH]; // R23
  wire rx_flush = hit(req, REG_COMMAND, 1'b1) && wdata_i[CMD_RX_FLUSH]; // R23
  wire tx_on = ctrl_q[CTRL_TX_EN] && !ctrl_q[CTRL_MODE_RX]; // R17
  wire rx_on = ctrl_q[CTRL_RX_EN] && ctrl_q[CTRL_MODE_RX];  // R17

  // configuration registers
  // unmapped and read-only offsets fall through to the
  // default branch, so writes there are simply dropped
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      ctrl_q     <= '0;
      car_div_q  <= DIV_RESET;
      car_high_q <= HIGH_RESET;
      smp_div_q  <= DIV_RESET;
      comp_div_q <= DIV_RESET;
      tx_thr_q   <= '0;
      rx_thr_q   <= '0;
      limit_q    <= '0;
      irq_en_q   <= '0;
      irq_mask_q <= '0;
    end else if (req.wr) begin
      case (req.addr)
        REG_CTRL:      ctrl_q     <= wdata_i[4:0]; // R17 R20 R10
        REG_CARRIER: begin
          car_div_q  <= wdata_i[15:0]; // R22
          car_high_q <= wdata_i[31:16];
        end
        REG_SAMPLE:    smp_div_q  <= wdata_i[15:0]; // R22
        REG_COMP:      comp_div_q <= wdata_i[15:0];
        REG_THRESH: begin
          tx_thr_q <= wdata_i[CNT_W-1:0];
          rx_thr_q <= wdata_i[8+CNT_W-1:8];
        end
        REG_CNT_LIMIT: limit_q    <= wdata_i[LIMIT_W-1:0]; // R11
        REG_IRQ_EN:    irq_en_q   <= wdata_i[IRQ_N-1:0]; // R13
        REG_IRQ_MASK:  irq_mask_q <= wdata_i[IRQ_N-1:0]; // R14
        default: ;
      endcase
    end
  end

  // manual start latch, dropped when receive is switched off
  // a start written while receive is off is lost on purpose:
  // software must enable first, then trigger
  always_ff @(posedge sys_clk_i) begin
    if (srst_i || !rx_on) begin
      start_q <= 1'b0;
    end else if (hit(req, REG_COMMAND, 1'b1) && wdata_i[CMD_RX_START]) begin
      start_q <= 1'b1; // R20
    end
  end

  // transmit fifo
  // eight flop entries; pointers wrap naturally at three bits
  // and the count carries one extra bit to tell full from empty
  // a write while full is dropped and flagged as overflow
  logic [31:0]      tx_mem [FIFO_DEPTH];
  logic [2:0]       tx_wp_q, tx_rp_q;
  logic [CNT_W-1:0] tx_cnt_q;
  logic             tx_pop;
  wire tx_push = hit(req, REG_TX_FIFO, 1'b1) && (tx_cnt_q != CNT_W'(FIFO_DEPTH));

  always_ff @(posedge sys_clk_i) begin
    if (tx_push) begin
      tx_mem[tx_wp_q] <= wdata_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i || tx_flush) begin
      tx_wp_q  <= '0;
      tx_rp_q  <= '0;
      tx_cnt_q <= '0; // R23
    end else begin
      tx_wp_q  <= tx_wp_q + 3'(tx_push);
      tx_rp_q  <= tx_rp_q + 3'(tx_pop);
      tx_cnt_q <= tx_cnt_q + CNT_W'(tx_push) - CNT_W'(tx_pop);
    end
  end

  // carrier and compensation dividers
  // both phases restart when tx is switched off, so the first
  // symbol after enabling always meets a whole carrier period
  // a divider of one leaves the phase at zero (zero gives 65536 cycles): the carrier
  // then wraps every cycle and the high part may cover it fully
  logic [15:0] car_ph_q, comp_ph_q;
  wire car_wrap  = (car_ph_q >= car_div_q - 16'h0001);
  wire comp_wrap = (comp_ph_q >= comp_div_q - 16'h0001);
  always_ff @(posedge sys_clk_i) begin
    if (srst_i || !tx_on) begin
      car_ph_q  <= '0;
      comp_ph_q <= '0;
    end else begin
      car_ph_q  <= car_wrap ? '0 : car_ph_q + 16'h0001; // R22
      comp_ph_q <= comp_wrap ? '0 : comp_ph_q + 16'h0001;
    end
  end

  // transmit engine
  // a symbol ends on its own tick; the next one is taken only
  // on a carrier wrap, so every carrier symbol opens with a
  // full high part; after an idle symbol timed on the
  // compensation clock the engine waits in the load state
  // for that wrap, which can add up to one carrier period
  // a count of zero ends in its first run cycle, which for a carrier symbol still drives one cycle of high part
  tx_state_t         tx_st_q;
  logic [31:0]       sym_q;
  logic [TX_CNT_W-1:0] sym_cnt_q;
  wire use_aux  = !sym_q[TX_TYPE_BIT] && (sym_q[TX_COMP_HI:TX_COMP_LO] == COMP_AUX); // R21
  wire sym_tick = use_aux ? comp_wrap : car_wrap;
  wire sym_end  = (tx_st_q == TX_RUN)
                  && (sym_cnt_q == '0 || (sym_tick && sym_cnt_q == TX_CNT_W'(1)));
  assign tx_pop = tx_on && (tx_cnt_q != '0) && !tx_flush && car_wrap
                  && (tx_st_q != TX_RUN || (sym_end && !sym_q[TX_LAST_BIT]));

  // symbol sequencing; a symbol starts on a carrier period edge
  always_ff @(posedge sys_clk_i) begin
    if (srst_i || !tx_on) begin
      tx_st_q   <= TX_IDLE;
      sym_q     <= '0;
      sym_cnt_q <= '0;
    end else begin
      case (tx_st_q)
        TX_IDLE, TX_LOAD: begin
          if (tx_pop) begin
            sym_q     <= tx_mem[tx_rp_q];
            sym_cnt_q <= tx_mem[tx_rp_q][TX_CNT_W-1:0]; // R3
            tx_st_q   <= TX_RUN;
          end else if (tx_st_q == TX_LOAD && tx_cnt_q == '0) begin
            tx_st_q   <= TX_IDLE; // underrun: wait for more symbols
          end
        end
        TX_RUN: begin
          if (tx_pop) begin
            sym_q     <= tx_mem[tx_rp_q]; // R1
            sym_cnt_q <= tx_mem[tx_rp_q][TX_CNT_W-1:0]; // R3
          end else if (sym_end) begin
            tx_st_q <= sym_q[TX_LAST_BIT] ? TX_IDLE : TX_LOAD; // R2
          end else if (sym_tick) begin
            sym_cnt_q <= sym_cnt_q - TX_CNT_W'(1); // R3
          end
        end
        default: tx_st_q <= TX_IDLE;
      endcase
    end
  end

  // pin driven from a flop; carrier high part then low part of each period
  // the pin lags the state by one cycle, which every symbol
  // shares, so the symbol lengths on the pin are unchanged
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      infrared_output_pin_o <= 1'b0;
    end else begin
      infrared_output_pin_o <= (tx_st_q == TX_RUN) && sym_q[TX_TYPE_BIT]
                               && (car_ph_q < car_high_q); // R1 R4
    end
  end

  // receive capture
  // the first sample after enabling only seeds the level;
  // it is not an edge, so no word of zero duration is queued
  // a level longer than the counter reaches saturates and
  // raises the counter overflow source once per sample
  logic [15:0]         smp_ph_q;
  logic [RX_CNT_W-1:0] lvl_cnt_q;
  logic                lvl_q, rx_run_q, cnt_of;
  wire smp_tick = (smp_ph_q >= smp_div_q - 16'h0001);
  wire rx_go    = rx_on && (!ctrl_q[CTRL_MANUAL] || start_q); // R20
  wire edge_seen = rx_run_q && smp_tick && (infrared_input_pin_i != lvl_q);
  assign cnt_of = rx_run_q && smp_tick && !edge_seen && (&lvl_cnt_q);

  always_ff @(posedge sys_clk_i) begin
    if (srst_i || !rx_go) begin
      smp_ph_q  <= '0;
      lvl_cnt_q <= '0;
      lvl_q     <= 1'b0;
      rx_run_q  <= 1'b0;
    end else begin
      smp_ph_q <= smp_tick ? '0 : smp_ph_q + 16'h0001; // R22
      if (smp_tick) begin
        if (!rx_run_q || edge_seen) begin
          rx_run_q  <= 1'b1;
          lvl_q     <= infrared_input_pin_i;
          lvl_cnt_q <= RX_CNT_W'(1);
        end else if (!(&lvl_cnt_q)) begin
          lvl_cnt_q <= lvl_cnt_q + RX_CNT_W'(1); // R7 saturates
        end
      end
    end
  end

  // receive fifo
  // a level that ends while the fifo is full is lost and
  // flagged as overflow; reading an empty fifo returns zero
  logic [31:0]      rx_mem [FIFO_DEPTH];
  logic [2:0]       rx_wp_q, rx_rp_q;
  logic [CNT_W-1:0] rx_cnt_q;
  wire rx_full  = (rx_cnt_q == CNT_W'(FIFO_DEPTH));
  wire rx_push  = edge_seen && !rx_full; // R5
  wire rx_read  = hit(req, REG_RX_FIFO, 1'b0);
  wire rx_pop   = rx_read && (rx_cnt_q != '0);

  always_ff @(posedge sys_clk_i) begin
    if (rx_push) begin
      rx_mem[rx_wp_q] <= {~lvl_q, lvl_cnt_q}; // R6 R7
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i || rx_flush) begin
      rx_wp_q  <= '0;
      rx_rp_q  <= '0;
      rx_cnt_q <= '0; // R23
    end else begin
      rx_wp_q  <= rx_wp_q + 3'(rx_push);
      rx_rp_q  <= rx_rp_q + 3'(rx_pop);
      rx_cnt_q <= rx_cnt_q + CNT_W'(rx_push) - CNT_W'(rx_pop);
    end
  end

  // interrupts
  // level sources keep setting their pending bit while true,
  // so clearing one whose condition still holds has no effect
  wire lvl_sel  = ctrl_q[CTRL_CNT_HI] ? lvl_q : !lvl_q; // R10
  always_comb begin
    irq_set                 = '0;
    irq_set[IRQ_TX_EMPTY]   = tx_cnt_q == '0;
    irq_set[IRQ_TX_LEVEL]   = tx_cnt_q <= tx_thr_q; // R8
    irq_set[IRQ_TX_OVER]    = hit(req, REG_TX_FIFO, 1'b1) && !tx_push;
    irq_set[IRQ_RX_FULL]    = rx_full;
    irq_set[IRQ_RX_LEVEL]   = rx_cnt_q > rx_thr_q; // R9
    irq_set[IRQ_RX_CNT_OF]  = cnt_of;
    irq_set[IRQ_RX_OVER]    = edge_seen && rx_full;
    irq_set[IRQ_RX_CNT_THR] = rx_run_q && lvl_sel
                              && (lvl_cnt_q >= RX_CNT_W'(limit_q)); // R10 R11
    irq_set[IRQ_RX_ERR]     = rx_read && (rx_cnt_q == '0); // R12
  end

  // pending bits: set wins over a same-cycle clear
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      irq_raw_q <= '0;
    end else begin
      irq_raw_q <= (irq_raw_q & ~(hit(req, REG_IRQ_CLR, 1'b1) ? wdata_i[IRQ_N-1:0] : '0))
                   | (irq_set & irq_en_q); // R13 R15
    end
  end
  assign irq_o = |(irq_raw_q & ~irq_mask_q); // R14

  // read data, one cycle after the strobe
  // data are zero outside the answer cycle so that the read
  // port can be or-ed with other slaves without a mux
  always_ff @(posedge sys_clk_i) begin
    if (srst_i || !req.rd) begin
      rdata_o <= '0;
    end else begin
      case (req.addr)
        REG_RX_FIFO:   rdata_o <= rx_pop ? rx_mem[rx_rp_q] : '0;
        REG_CTRL:      rdata_o <= 32'(ctrl_q);
        REG_CARRIER:   rdata_o <= {car_high_q, car_div_q};
        REG_SAMPLE:    rdata_o <= 32'(smp_div_q);
        REG_COMP:      rdata_o <= 32'(comp_div_q);
        REG_THRESH:    rdata_o <= {20'h00000, rx_thr_q, 4'h0, tx_thr_q};
        REG_CNT_LIMIT: rdata_o <= 32'(limit_q);
        REG_IRQ_EN:    rdata_o <= 32'(irq_en_q);
        REG_IRQ_MASK:  rdata_o <= 32'(irq_mask_q); // R14
        REG_IRQ_RAW:   rdata_o <= 32'(irq_raw_q); // R14
        REG_STATUS:    rdata_o <= {15'h0000, (tx_st_q != TX_IDLE) || rx_run_q, // R16
                                   4'h0, rx_cnt_q, // R19
                                   4'h0, CNT_W'(FIFO_DEPTH) - tx_cnt_q}; // R18
        default:       rdata_o <= '0;
      endcase
    end
  end
endmodule : ir_transceiver

// *** ir_transceiver_monitor.sv ***
// checker: port-level behaviour of the infrared transceiver
`timescale 1ns/1ps
module ir_transceiver_monitor
  import ir_pkg::*;
(
  // clock and reset
  input wire logic        sys_clk_i,
  input wire logic        srst_i,
  // register port
  input wire logic [7:0]  addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [31:0] rdata_o,
  // pins and interrupt
  input wire logic        infrared_input_pin_i,
  input wire logic        infrared_output_pin_o,
  input wire logic        irq_o
);
  logic [4:0]       ctrl_q;
  logic [IRQ_N-1:0] en_q;
  logic [IRQ_N-1:0] mask_q;
  logic             tx_act;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);

  // shadow copies of software controls, updated on the same edge as the design
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      ctrl_q <= '0;
      en_q   <= '0;
      mask_q <= '0;
    end else if (wr_i) begin
      if (addr_i == REG_CTRL) ctrl_q <= wdata_i[4:0];
      if (addr_i == REG_IRQ_EN) en_q <= wdata_i[IRQ_N-1:0];
      if (addr_i == REG_IRQ_MASK) mask_q <= wdata_i[IRQ_N-1:0];
    end
  end

  // tx engine may run only when enabled in tx mode
  assign tx_act = ctrl_q[CTRL_TX_EN] && !ctrl_q[CTRL_MODE_RX];

  sequence s_tx_off;
    (!tx_act)[*3];
  endsequence
  sequence s_clr_all;
    wr_i && addr_i == REG_IRQ_CLR && wdata_i[IRQ_N-1:0] == '1 && en_q == '0;
  endsequence

  property p_reset_quiet;
    $fell(srst_i) |-> rdata_o == '0 && !infrared_output_pin_o && !irq_o;
  endproperty
  property p_rd_idle;
    !rd_i |=> rdata_o == '0;
  endproperty
  property p_unmapped;
    rd_i && addr_i > REG_COMMAND |=> rdata_o == '0;
  endproperty
  property p_rx_word;
    rd_i && addr_i == REG_RX_FIFO |=> rdata_o == '0 || rdata_o[30:0] != '0;
  endproperty
  property p_status;
    rd_i && addr_i == REG_STATUS |=> rdata_o[3:0] <= FIFO_DEPTH && rdata_o[11:8] <= FIFO_DEPTH;
  endproperty
  property p_pin_off;
    s_tx_off |-> !infrared_output_pin_o;
  endproperty
  property p_mask;
    mask_q == '1 |-> !irq_o;
  endproperty
  property p_clear;
    s_clr_all |=> !irq_o;
  endproperty

  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not quiet after reset");
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read answer");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_rx_word: assert property (p_rx_word) else $error("rx word with zero duration");
  a_status: assert property (p_status) else $error("fifo counts beyond depth");
  a_pin_off: assert property (p_pin_off) else $error("emitter active while tx off");
  a_mask: assert property (p_mask) else $error("irq while all masked");
  a_clear: assert property (p_clear) else $error("irq after full clear");
endmodule : ir_transceiver_monitor

bind ir_transceiver ir_transceiver_monitor u_mon (
  .sys_clk_i(sys_clk_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .infrared_input_pin_i(infrared_input_pin_i),
  .infrared_output_pin_o(infrared_output_pin_o), .irq_o(irq_o));

// *** ir_partner.sv ***
// partner: emitter pulse counter and demodulating receiver stand-in
`timescale 1ns/1ps
module ir_partner (
  // clock
  input  wire logic       sys_clk_i,
  // emitter side
  input  wire logic       led_i,
  output logic      [7:0] pulses_o,
  // receiver side
  input  wire logic [7:0] low_len_i,
  input  wire logic       play_i,
  output logic            rx_o
);
  logic       led_q  = 1'b0;
  logic [7:0] cnt_q  = 8'h00;
  logic [7:0] left_q = 8'h00;

  // each rising edge is one carrier pulse seen by the far end
  always_ff @(posedge sys_clk_i) begin
    led_q <= led_i;
    if (led_i && !led_q) cnt_q <= cnt_q + 8'h01;
  end

  // demodulated output idles high, goes low for one burst of low_len cycles
  always_ff @(posedge sys_clk_i) begin
    if (play_i) left_q <= low_len_i;
    else if (left_q != 8'h00) left_q <= left_q - 8'h01;
  end

  assign pulses_o = cnt_q;
  assign rx_o     = (left_q == 8'h00);
endmodule : ir_partner

// *** tb_ir_transceiver.sv ***
// testbench: register-level scenarios for the infrared transceiver
`timescale 1ns/1ps
module tb_ir_transceiver;
  import ir_pkg::*;
  logic        sys_clk_i = 1'b0;
  logic        srst_i    = 1'b1;
  logic [7:0]  addr_i    = 8'h00;
  logic [31:0] wdata_i   = 32'h0000_0000;
  logic        wr_i      = 1'b0;
  logic        rd_i      = 1'b0;
  logic        play      = 1'b0;
  logic [31:0] rdata_o;
  logic        ir_in;
  logic        ir_out;
  logic        irq_o;
  logic [7:0]  pulses;
  logic [7:0]  p0;
  logic [31:0] rv;
  int          err_count   = 0;
  int          checks_done = 0;

  // 20 MHz system clock
  always #25 sys_clk_i = ~sys_clk_i;

  ir_transceiver u_dut (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .infrared_input_pin_i(ir_in),
    .infrared_output_pin_o(ir_out), .irq_o(irq_o));
  ir_partner u_far (.sys_clk_i(sys_clk_i), .led_i(ir_out), .pulses_o(pulses),
    .low_len_i(8'h1E), .play_i(play), .rx_o(ir_in));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // one-cycle strobes, released right after the edge that takes them
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask : rd_reg

  task automatic expect_rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rd_reg(a, rv);
    check(rv & m, e);
  endtask : expect_rd

  // one low burst from the receiver, then let it settle
  task automatic burst;
    @(posedge sys_clk_i);
    play <= 1'b1;
    @(posedge sys_clk_i);
    play <= 1'b0;
    repeat (50) @(posedge sys_clk_i);
  endtask : burst

  task automatic end_of_test;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_of_test

  // watchdog far beyond the under one thousand cycles the sequence needs
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    err_count++;
    end_of_test();
  end

  initial begin
    repeat (8) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    expect_rd(REG_CARRIER, 32'hFFFF_FFFF, {HIGH_RESET, DIV_RESET});
    expect_rd(REG_STATUS, 32'hFFFF_FFFF, 32'h0000_0008);
    expect_rd(8'h3C, 32'hFFFF_FFFF, 32'h0000_0000);
    // short carrier keeps the symbol walk brief: period 4, high 2
    wr_reg(REG_CARRIER, 32'h0002_0004);
    wr_reg(REG_TX_FIFO, 32'h8000_0003);
    wr_reg(REG_TX_FIFO, 32'h0000_0002);
    wr_reg(REG_TX_FIFO, 32'hC000_0002);
    expect_rd(REG_STATUS, 32'h0000_000F, 32'h0000_0005);
    p0 = pulses;
    wr_reg(REG_CTRL, 32'h0000_0001);
    repeat (8) @(posedge sys_clk_i);
    expect_rd(REG_STATUS, 32'h0001_0000, 32'h0001_0000);
    for (int n = 0; n < 100 && rv[16] !== 1'b0; n++) rd_reg(REG_STATUS, rv);
    check({24'h000000, pulses - p0}, 32'h0000_0005);
    expect_rd(REG_STATUS, 32'h0001_000F, 32'h0000_0008);
    // idle symbol on the slow compensation clock, then one carrier period
    wr_reg(REG_CTRL, 32'h0000_0000);
    wr_reg(REG_COMP, 32'h0000_0100);
    wr_reg(REG_TX_FIFO, 32'h3000_0002);
    wr_reg(REG_TX_FIFO, 32'hC000_0001);
    p0 = pulses;
    wr_reg(REG_CTRL, 32'h0000_0001);
    repeat (100) @(posedge sys_clk_i);
    check({24'h000000, pulses - p0}, 32'h0000_0000);
    rv = 32'h0001_0000;
    for (int n = 0; n < 400 && rv[16] !== 1'b0; n++) rd_reg(REG_STATUS, rv);
    check(rv & 32'h0001_0000, 32'h0000_0000);
    check({24'h000000, pulses - p0}, 32'h0000_0001);
    // overfill with tx off, then flush
    wr_reg(REG_CTRL, 32'h0000_0000);
    wr_reg(REG_IRQ_EN, 32'h0000_01FF);
    for (int i = 0; i < 9; i++) wr_reg(REG_TX_FIFO, 32'h8000_0001);
    expect_rd(REG_STATUS, 32'h0000_000F, 32'h0000_0000);
    expect_rd(REG_IRQ_RAW, 32'h0000_0004, 32'h0000_0004);
    wr_reg(REG_IRQ_CLR, 32'h0000_0004);
    expect_rd(REG_IRQ_RAW, 32'h0000_0004, 32'h0000_0000);
    wr_reg(REG_COMMAND, 32'h0000_0001);
    expect_rd(REG_STATUS, 32'h0000_000F, 32'h0000_0008);
    expect_rd(REG_IRQ_RAW, 32'h0000_0003, 32'h0000_0003);
    wr_reg(REG_IRQ_MASK, 32'h0000_01FF);
    expect_rd(REG_IRQ_MASK, 32'hFFFF_FFFF, 32'h0000_01FF);
    check({31'h0, irq_o}, 32'h0000_0000);
    wr_reg(REG_IRQ_MASK, 32'h0000_0000);
    #1 check({31'h0, irq_o}, 32'h0000_0001);
    // capture one 30-cycle low burst, sampling every cycle
    wr_reg(REG_SAMPLE, 32'h0000_0001);
    wr_reg(REG_THRESH, 32'h0000_0100);
    wr_reg(REG_CNT_LIMIT, 32'h0000_000A);
    wr_reg(REG_CTRL, 32'h0000_0006);
    burst();
    expect_rd(REG_STATUS, 32'h0000_0F00, 32'h0000_0200);
    expect_rd(REG_IRQ_RAW, 32'h0000_0090, 32'h0000_0090);
    expect_rd(REG_RX_FIFO, 32'h8000_0000, 32'h0000_0000);
    expect_rd(REG_RX_FIFO, 32'hFFFF_FFFF, 32'h8000_001E);
    expect_rd(REG_RX_FIFO, 32'hFFFF_FFFF, 32'h0000_0000);
    expect_rd(REG_IRQ_RAW, 32'h0000_0100, 32'h0000_0100);
    // manual capture stays silent until the start command
    wr_reg(REG_CTRL, 32'h0000_0000);
    wr_reg(REG_CTRL, 32'h0000_000E);
    burst();
    expect_rd(REG_STATUS, 32'h0000_0F00, 32'h0000_0000);
    wr_reg(REG_COMMAND, 32'h0000_0004);
    burst();
    expect_rd(REG_STATUS, 32'h0000_0F00, 32'h0000_0200);
    wr_reg(REG_COMMAND, 32'h0000_0002);
    expect_rd(REG_STATUS, 32'h0000_0F00, 32'h0000_0000);
    // nothing may re-raise once enables are off and all is cleared
    wr_reg(REG_IRQ_EN, 32'h0000_0000);
    wr_reg(REG_IRQ_CLR, 32'h0000_01FF);
    #1 check({31'h0, irq_o}, 32'h0000_0000);
    end_of_test();
  end
endmodule : tb_ir_transceiver
